// ---- eam_alu.sv ----
// How it works
// - Add and add-with-carry sum source into destination, write it, set Z C N V H, one clock.
// - Word add immediate adds a small constant to a register pair, writes it, sets Z C N V S, two clocks.
// - Word subtract immediate subtracts a small constant from a pair, writes it, sets Z C N V S, two clocks.
// - Subtract with borrow takes destination minus source minus carry, sets Z C N V H, one clock.
// - Subtract immediate takes a constant from the destination, sets Z C N V H, one clock.
// - Subtract constant with borrow takes constant and carry from the destination, one clock.
// - AND with a register or constant stores the result and sets only Z N V, one clock.
// - OR with a register or constant stores the result and sets only Z N V, one clock.
// - Set-bits ORs a mask into the destination and sets Z N V, one clock.
// - Clear-bits ANDs the destination with the mask inverted against all ones, one clock.
// - Test ANDs a register with itself and sets Z N V from it, one clock.
// - Mixed-sign multiply puts signed times unsigned into the R1:R0 pair, sets Z C, two clocks.
// - Fractional unsigned multiply shifts the unsigned product left by one into R1:R0, sets Z C.
// - Fractional mixed multiply shifts the mixed product left by one into R1:R0, sets Z C, two clocks.
`timescale 1ns/1ps
`default_nettype none
module eam_alu
  import eam_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       req_valid,
  input  wire eam_req_t   req,
  output logic            busy_reg,
  output logic            res_valid_reg,
  output eam_res_t        res_reg,
  output eam_flags_t      flags_reg
);

  // ********************************************************************
  // Decode helpers
  // ********************************************************************
  function automatic logic is_mul(input eam_op_t op);
    case (op)
      OP_UNSIGNED_MULTIPLY, OP_SIGNED_MULTIPLY, OP_MIXED_SIGN_MULTIPLY,
      OP_FRACTIONAL_UNSIGNED_MULTIPLY, OP_FRACTIONAL_SIGNED_MULTIPLY,
      OP_FRACTIONAL_MIXED_MULTIPLY: is_mul = 1'b1;
      default: is_mul = 1'b0;
    endcase
  endfunction : is_mul

  function automatic logic [1:0] op_cycles(input eam_op_t op);
    if (op == OP_WORD_ADD_IMMEDIATE || op == OP_WORD_SUBTRACT_IMMEDIATE) begin
      op_cycles = EAM_WORD_CYCLES;
    end else if (is_mul(op)) begin
      op_cycles = EAM_MUL_CYCLES;
    end else begin
      op_cycles = EAM_BYTE_CYCLES;
    end
  endfunction : op_cycles

  // ********************************************************************
  // Issue control
  // ********************************************************************
  logic                      accept;
  logic                      commit;
  logic [1:0]                cnt_reg;
  eam_op_t                   hold_op_reg;
  logic [15:0]               hold_word_reg;
  logic [EAM_WORD_IMM_W-1:0] hold_k_reg;

  assign accept = req_valid & ~busy_reg;
  assign commit = busy_reg & (cnt_reg == 2'd1);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg <= 1'b0;
      cnt_reg  <= 2'd0;
    end else if (accept && op_cycles(req.op) != EAM_BYTE_CYCLES) begin
      busy_reg <= 1'b1;
      cnt_reg  <= op_cycles(req.op) - 2'd1;
    end else if (commit) begin
      busy_reg <= 1'b0;
      cnt_reg  <= 2'd0;
    end else if (busy_reg) begin
      cnt_reg  <= cnt_reg - 2'd1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_op_reg   <= OP_ADD;
      hold_word_reg <= 16'h0000;
      hold_k_reg    <= '0;
    end else if (accept) begin
      hold_op_reg   <= req.op;
      hold_word_reg <= {req.dst_hi, req.dst};
      hold_k_reg    <= req.src[EAM_WORD_IMM_W-1:0];
    end
  end

  // ********************************************************************
  // Multiplier
  // ********************************************************************
  logic        mul_a_signed;
  logic        mul_b_signed;
  logic        mul_frac;
  logic [15:0] mul_product;
  logic        mul_carry;

  always_comb begin
    mul_a_signed = 1'b0;
    mul_b_signed = 1'b0;
    mul_frac     = 1'b0;
    case (req.op)
      OP_SIGNED_MULTIPLY: begin
        mul_a_signed = 1'b1;
        mul_b_signed = 1'b1;
      end
      OP_MIXED_SIGN_MULTIPLY: mul_a_signed = 1'b1;
      OP_FRACTIONAL_UNSIGNED_MULTIPLY: mul_frac = 1'b1;
      OP_FRACTIONAL_SIGNED_MULTIPLY: begin
        mul_a_signed = 1'b1;
        mul_b_signed = 1'b1;
        mul_frac     = 1'b1;
      end
      OP_FRACTIONAL_MIXED_MULTIPLY: begin
        mul_a_signed = 1'b1;
        mul_frac     = 1'b1;
      end
      default: mul_frac = 1'b0;
    endcase
  end

  eam_mul #(.W(8)) u_mul (
    .clk         (clk),
    .arst_n      (arst_n),
    .load        (accept & is_mul(req.op)),
    .a           (req.dst),
    .b           (req.src),
    .a_signed    (mul_a_signed),
    .b_signed    (mul_b_signed),
    .frac        (mul_frac),
    .product_reg (mul_product),
    .carry_reg   (mul_carry)
  );

  // ********************************************************************
  // Byte arithmetic and logic
  // ********************************************************************
  logic       use_carry;
  logic       is_sub;
  logic       is_logic;
  logic       cin;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [7:0] arith_r;
  logic [7:0] logic_r;
  logic       arith_v;

  always_comb begin
    use_carry = (req.op == OP_ADD_CARRY) || (req.op == OP_SUBTRACT_WITH_BORROW)
                || (req.op == OP_SUBTRACT_CONSTANT_WITH_BORROW);
    is_sub    = (req.op == OP_SUBTRACT) || (req.op == OP_SUBTRACT_IMMEDIATE)
                || (req.op == OP_SUBTRACT_WITH_BORROW) || (req.op == OP_SUBTRACT_CONSTANT_WITH_BORROW);
    cin       = use_carry & flags_reg.c;
    if (is_sub) begin
      sum9 = {1'b0, req.dst} - {1'b0, req.src} - {8'h00, cin};
      nib5 = {1'b0, req.dst[3:0]} - {1'b0, req.src[3:0]} - {4'h0, cin};
    end else begin
      sum9 = {1'b0, req.dst} + {1'b0, req.src} + {8'h00, cin};
      nib5 = {1'b0, req.dst[3:0]} + {1'b0, req.src[3:0]} + {4'h0, cin};
    end
    arith_r = sum9[7:0];
    if (is_sub) begin
      arith_v = (req.dst[EAM_BYTE_MSB] != req.src[EAM_BYTE_MSB])
                && (arith_r[EAM_BYTE_MSB] != req.dst[EAM_BYTE_MSB]);
    end else begin
      arith_v = (req.dst[EAM_BYTE_MSB] == req.src[EAM_BYTE_MSB])
                && (arith_r[EAM_BYTE_MSB] != req.dst[EAM_BYTE_MSB]);
    end
    is_logic = 1'b1;
    case (req.op)
      OP_AND, OP_AND_IMMEDIATE: logic_r = req.dst & req.src;
      OP_OR, OP_OR_IMMEDIATE: logic_r = req.dst | req.src;
      OP_SET_BITS_BY_MASK: logic_r = req.dst | req.src;
      OP_CLEAR_BITS_BY_MASK: logic_r = req.dst & (EAM_ALL_ONES ^ req.src);
      OP_TEST_ZERO_OR_MINUS: logic_r = req.dst & req.dst;
      default: begin
        logic_r  = 8'h00;
        is_logic = 1'b0;
      end
    endcase
  end

  // ********************************************************************
  // Word arithmetic on the held pair
  // ********************************************************************
  logic        word_sub;
  logic [15:0] word_r;
  logic        word_v;
  logic        word_c;

  always_comb begin
    word_sub = (hold_op_reg == OP_WORD_SUBTRACT_IMMEDIATE);
    if (word_sub) begin
      word_r = hold_word_reg - {{(16-EAM_WORD_IMM_W){1'b0}}, hold_k_reg};
      word_v = hold_word_reg[EAM_WORD_MSB] & ~word_r[EAM_WORD_MSB];
      word_c = word_r[EAM_WORD_MSB] & ~hold_word_reg[EAM_WORD_MSB];
    end else begin
      word_r = hold_word_reg + {{(16-EAM_WORD_IMM_W){1'b0}}, hold_k_reg};
      word_v = ~hold_word_reg[EAM_WORD_MSB] & word_r[EAM_WORD_MSB];
      word_c = ~word_r[EAM_WORD_MSB] & hold_word_reg[EAM_WORD_MSB];
    end
  end

  // ********************************************************************
  // Result and flag selection
  // ********************************************************************
  logic       valid_next;
  eam_res_t   res_next;
  eam_flags_t flags_next;

  always_comb begin
    valid_next = 1'b0;
    res_next   = res_reg;
    flags_next = flags_reg;
    if (commit) begin
      valid_next = 1'b1;
      if (is_mul(hold_op_reg)) begin
        res_next.dest = DEST_PRODUCT;
        res_next.data = mul_product;
        flags_next.c  = mul_carry;
        flags_next.z  = (mul_product == 16'h0000);
      end else begin
        res_next.dest = DEST_PAIR;
        res_next.data = word_r;
        flags_next.c  = word_c;
        flags_next.v  = word_v;
        flags_next.n  = word_r[EAM_WORD_MSB];
        flags_next.s  = word_r[EAM_WORD_MSB] ^ word_v;
        flags_next.z  = (word_r == 16'h0000);
      end
    end else if (accept && op_cycles(req.op) == EAM_BYTE_CYCLES) begin
      valid_next    = 1'b1;
      res_next.dest = DEST_BYTE;
      if (is_logic) begin
        res_next.data = {8'h00, logic_r};
        flags_next.z  = (logic_r == 8'h00);
        flags_next.n  = logic_r[EAM_BYTE_MSB];
        flags_next.v  = 1'b0;
      end else begin
        res_next.data = {8'h00, arith_r};
        flags_next.c  = sum9[8];
        flags_next.h  = nib5[EAM_NIBBLE_MSB+1];
        flags_next.n  = arith_r[EAM_BYTE_MSB];
        flags_next.v  = arith_v;
        // Borrow variants only keep zero if the previous step was zero
        flags_next.z  = (arith_r == 8'h00) & (~use_carry | ~is_sub | flags_reg.z);
      end
    end
  end

  // ********************************************************************
  // Output registers
  // ********************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      res_valid_reg <= 1'b0;
      res_reg       <= '0;
    end else begin
      res_valid_reg <= valid_next;
      res_reg       <= res_next;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_reg <= EAM_FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

endmodule : eam_alu
`default_nettype wire

// ---- eam_alu_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module eam_alu_properties
  import eam_pkg::*;
(
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       req_valid,
  input wire eam_req_t   req,
  input wire logic       busy_reg,
  input wire logic       res_valid_reg,
  input wire eam_res_t   res_reg,
  input wire eam_flags_t flags_reg
);
  // ****************
  // Request classes
  // ****************
  logic taken;
  logic byte_op;
  logic logic_op;
  logic word_op;
  logic mul_op;
  assign taken    = req_valid && !busy_reg;
  assign byte_op  = taken && (req.op inside {[OP_ADD:OP_TEST_ZERO_OR_MINUS]});
  assign logic_op = taken && (req.op inside {[OP_AND:OP_TEST_ZERO_OR_MINUS]});
  assign word_op  = taken && (req.op inside {OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE});
  assign mul_op   = taken && (req.op inside {[OP_UNSIGNED_MULTIPLY:OP_FRACTIONAL_MIXED_MULTIPLY]});

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ****************
  // Checks
  // ****************
  a_byte_latency: assert property (byte_op |=> res_valid_reg && !busy_reg)
    else $error("byte result late");
  a_word_latency: assert property (word_op |=> busy_reg && !res_valid_reg ##1
    res_valid_reg && !busy_reg && res_reg.dest == DEST_PAIR) else $error("word result timing");
  a_mul_latency: assert property (mul_op |=> !res_valid_reg ##1
    res_valid_reg && res_reg.dest == DEST_PRODUCT) else $error("product timing");
  a_flags_hold: assert property (!res_valid_reg |-> $stable(flags_reg))
    else $error("flags moved without result");
  a_logic_flags: assert property (logic_op |=> !flags_reg.v && $stable(flags_reg.c)
    && flags_reg.z == (res_reg.data[7:0] == 8'h00) && flags_reg.n == res_reg.data[7]) else $error("logic flags");
  a_word_sign: assert property (res_valid_reg && res_reg.dest == DEST_PAIR |->
    flags_reg.s == (flags_reg.n ^ flags_reg.v) && flags_reg.n == res_reg.data[15]) else $error("word sign");
  a_mul_flags: assert property (res_valid_reg && res_reg.dest == DEST_PRODUCT |->
    flags_reg.z == (res_reg.data == 16'h0000) && $stable(flags_reg.n) && $stable(flags_reg.h)) else $error("mul flags");
  a_add_result: assert property (taken && req.op == OP_ADD |=>
    res_reg.data[7:0] == 8'($past(req.dst) + $past(req.src))) else $error("add sum");
  a_subtract_immediate_result: assert property (taken && req.op == OP_SUBTRACT_IMMEDIATE |=>
    res_reg.data[7:0] == 8'($past(req.dst) - $past(req.src)) && flags_reg.c == ($past(req.src) > $past(req.dst)))
    else $error("subtract result");
  a_busy_single: assert property (busy_reg |=> !busy_reg)
    else $error("busy too long");

  c_byte: cover property (byte_op);
  c_word: cover property (word_op);
  c_mul: cover property (mul_op);
endmodule : eam_alu_properties

bind eam_alu eam_alu_properties eam_alu_properties_i (.clk(clk), .arst_n(arst_n), .req_valid(req_valid),
  .req(req), .busy_reg(busy_reg), .res_valid_reg(res_valid_reg), .res_reg(res_reg), .flags_reg(flags_reg));
`default_nettype wire

// ---- eam_mul.sv ----
`timescale 1ns/1ps
`default_nettype none
module eam_mul
  import eam_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             load,
  input  wire logic [W-1:0]     a,
  input  wire logic [W-1:0]     b,
  input  wire logic             a_signed,
  input  wire logic             b_signed,
  input  wire logic             frac,
  output logic      [2*W-1:0]   product_reg,
  output logic                  carry_reg
);

  // ********************************************************************
  // Nine-bit extension covers signed, unsigned and mixed operands
  // ********************************************************************
  logic signed [W:0]     a_ext;
  logic signed [W:0]     b_ext;
  logic signed [2*W+1:0] full;
  logic        [2*W-1:0] raw;

  assign a_ext = $signed({a_signed & a[W-1], a});
  assign b_ext = $signed({b_signed & b[W-1], b});
  assign full  = a_ext * b_ext;
  assign raw   = full[2*W-1:0];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      product_reg <= '0;
      carry_reg   <= 1'b0;
    end else if (load) begin
      // Carry is taken from the product before the fractional shift
      carry_reg   <= raw[2*W-1];
      product_reg <= frac ? {raw[2*W-2:0], 1'b0} : raw;
    end
  end

endmodule : eam_mul
`default_nettype wire

// ---- eam_pkg.sv ----
package eam_pkg;

  // ********************************************************************
  // Operations
  // ********************************************************************
  typedef enum logic [4:0] {
    OP_ADD,
    OP_ADD_CARRY,
    OP_SUBTRACT,
    OP_SUBTRACT_IMMEDIATE,
    OP_SUBTRACT_WITH_BORROW,
    OP_SUBTRACT_CONSTANT_WITH_BORROW,
    OP_AND,
    OP_AND_IMMEDIATE,
    OP_OR,
    OP_OR_IMMEDIATE,
    OP_SET_BITS_BY_MASK,
    OP_CLEAR_BITS_BY_MASK,
    OP_TEST_ZERO_OR_MINUS,
    OP_WORD_ADD_IMMEDIATE,
    OP_WORD_SUBTRACT_IMMEDIATE,
    OP_UNSIGNED_MULTIPLY,
    OP_SIGNED_MULTIPLY,
    OP_MIXED_SIGN_MULTIPLY,
    OP_FRACTIONAL_UNSIGNED_MULTIPLY,
    OP_FRACTIONAL_SIGNED_MULTIPLY,
    OP_FRACTIONAL_MIXED_MULTIPLY
  } eam_op_t;

  typedef enum logic [1:0] {
    DEST_BYTE,
    DEST_PAIR,
    DEST_PRODUCT
  } eam_dest_t;

  // ********************************************************************
  // Carriers
  // ********************************************************************
  typedef struct packed {
    eam_op_t    op;
    logic [7:0] dst;
    logic [7:0] src;
    logic [7:0] dst_hi;
  } eam_req_t;

  typedef struct packed {
    eam_dest_t   dest;
    logic [15:0] data;
  } eam_res_t;

  typedef struct packed {
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } eam_flags_t;

  // ********************************************************************
  // Constants
  // ********************************************************************
  localparam logic [1:0] EAM_BYTE_CYCLES   = 2'd1;
  localparam logic [1:0] EAM_WORD_CYCLES   = 2'd2;
  localparam logic [1:0] EAM_MUL_CYCLES    = 2'd2;
  localparam int         EAM_WORD_IMM_W    = 6;
  localparam logic [7:0] EAM_ALL_ONES      = 8'hff;
  localparam eam_flags_t EAM_FLAGS_RESET   = 6'h00;
  localparam int         EAM_PRODUCT_LO    = 0;
  localparam int         EAM_PRODUCT_HI    = 1;
  localparam int         EAM_NIBBLE_MSB    = 3;
  localparam int         EAM_BYTE_MSB      = 7;
  localparam int         EAM_WORD_MSB      = 15;

endpackage : eam_pkg

// ---- eam_regfile_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module eam_regfile_model
  import eam_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     arst_n,
  input  wire logic     res_valid_reg,
  input  wire eam_res_t res_reg,
  output logic [7:0]    r0_reg,
  output logic [7:0]    r1_reg
);
  // ****************
  // Product pair write-back
  // ****************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r0_reg <= 8'h00;
      r1_reg <= 8'h00;
    end else if (res_valid_reg && res_reg.dest == DEST_PRODUCT) begin
      r0_reg <= res_reg.data[7:0];
      r1_reg <= res_reg.data[15:8];
    end
  end
endmodule : eam_regfile_model
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import eam_pkg::*;
;
  typedef struct packed {
    eam_op_t     op;
    logic [7:0]  d;
    logic [7:0]  s;
    logic [7:0]  h;
    eam_dest_t   dst;
    logic [15:0] dat;
    logic [5:0]  fl;
  } eam_row_t;

  logic       clk;
  logic       arst_n;
  logic       req_valid;
  eam_req_t   req;
  logic       busy_reg;
  logic       res_valid_reg;
  eam_res_t   res_reg;
  eam_flags_t flags_reg;
  logic [7:0] r0_reg;
  logic [7:0] r1_reg;
  int         failures;
  int         checks_done;
  int         n;

  eam_row_t rows [0:20] = '{
    '{OP_ADD, 8'h88, 8'h88, 8'h00, DEST_BYTE, 16'h0010, 6'h29},
    '{OP_ADD_CARRY, 8'h01, 8'h02, 8'h00, DEST_BYTE, 16'h0004, 6'h00},
    '{OP_SUBTRACT_IMMEDIATE, 8'h00, 8'h01, 8'h00, DEST_BYTE, 16'h00ff, 6'h25},
    '{OP_SUBTRACT_WITH_BORROW, 8'h05, 8'h04, 8'h00, DEST_BYTE, 16'h0000, 6'h00},
    '{OP_SUBTRACT_CONSTANT_WITH_BORROW, 8'h80, 8'h01, 8'h00, DEST_BYTE, 16'h007f, 6'h28},
    '{OP_AND_IMMEDIATE, 8'hf0, 8'h0f, 8'h00, DEST_BYTE, 16'h0000, 6'h22},
    '{OP_OR_IMMEDIATE, 8'h80, 8'h01, 8'h00, DEST_BYTE, 16'h0081, 6'h24},
    '{OP_SET_BITS_BY_MASK, 8'h10, 8'h01, 8'h00, DEST_BYTE, 16'h0011, 6'h20},
    '{OP_CLEAR_BITS_BY_MASK, 8'hff, 8'h0f, 8'h00, DEST_BYTE, 16'h00f0, 6'h24},
    '{OP_TEST_ZERO_OR_MINUS, 8'h00, 8'h00, 8'h00, DEST_BYTE, 16'h0000, 6'h22},
    '{OP_AND, 8'hc3, 8'h81, 8'h00, DEST_BYTE, 16'h0081, 6'h24},
    '{OP_OR, 8'h00, 8'h00, 8'h00, DEST_BYTE, 16'h0000, 6'h22},
    '{OP_SUBTRACT, 8'h10, 8'h10, 8'h00, DEST_BYTE, 16'h0000, 6'h02},
    '{OP_WORD_ADD_IMMEDIATE, 8'hff, 8'h3f, 8'h7f, DEST_PAIR, 16'h803e, 6'h0c},
    '{OP_MIXED_SIGN_MULTIPLY, 8'hff, 8'hff, 8'h00, DEST_PRODUCT, 16'hff01, 6'h0d},
    '{OP_WORD_SUBTRACT_IMMEDIATE, 8'h00, 8'hc1, 8'h00, DEST_PAIR, 16'hffff, 6'h15},
    '{OP_FRACTIONAL_UNSIGNED_MULTIPLY, 8'h80, 8'h02, 8'h00, DEST_PRODUCT, 16'h0200, 6'h14},
    '{OP_FRACTIONAL_MIXED_MULTIPLY, 8'h80, 8'h80, 8'h00, DEST_PRODUCT, 16'h8000, 6'h15},
    '{OP_UNSIGNED_MULTIPLY, 8'h00, 8'h12, 8'h00, DEST_PRODUCT, 16'h0000, 6'h16},
    '{OP_SIGNED_MULTIPLY, 8'hff, 8'hff, 8'h00, DEST_PRODUCT, 16'h0001, 6'h14},
    '{OP_FRACTIONAL_SIGNED_MULTIPLY, 8'h80, 8'h80, 8'h00, DEST_PRODUCT, 16'h8000, 6'h14}
  };

  eam_alu eam_alu_i (.clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req(req), .busy_reg(busy_reg),
    .res_valid_reg(res_valid_reg), .res_reg(res_reg), .flags_reg(flags_reg));
  eam_regfile_model eam_regfile_model_i (.clk(clk), .arst_n(arst_n), .res_valid_reg(res_valid_reg),
    .res_reg(res_reg), .r0_reg(r0_reg), .r1_reg(r1_reg));

  always #25 clk = ~clk;

  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task automatic run_row(input eam_row_t r);
    int k;
    k = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= '{r.op, r.d, r.s, r.h};
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    k = 1;
    while (res_valid_reg !== 1'b1 && k < 4) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(16'(k), (r.dst == DEST_BYTE) ? 16'h0001 : 16'h0002);
    chk({14'h0000, res_reg.dest}, {14'h0000, r.dst});
    chk((r.dst == DEST_BYTE) ? {8'h00, res_reg.data[7:0]} : res_reg.data, r.dat);
    chk({10'h000, flags_reg}, {10'h000, r.fl});
  endtask : run_row

  initial begin
    repeat (2000) @(posedge clk);
    failures++;
    test_done;
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    clk         = 1'b0;
    arst_n      = 1'b0;
    req_valid   = 1'b0;
    req         = '0;
    failures    = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk({6'h00, busy_reg, res_valid_reg, res_reg.dest, flags_reg}, 16'h0000);
    foreach (rows[i]) run_row(rows[i]);
    @(posedge clk);
    #1;
    chk({r1_reg, r0_reg}, 16'h8000);
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= '{OP_ADD, 8'h01, 8'h01, 8'h00};
    @(posedge clk);
    req       <= '{OP_OR, 8'h30, 8'h03, 8'h00};
    #1;
    chk({7'h00, res_valid_reg, res_reg.data[7:0]}, 16'h0102);
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    chk({7'h00, res_valid_reg, res_reg.data[7:0]}, 16'h0133);
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= '{OP_WORD_ADD_IMMEDIATE, 8'h00, 8'h01, 8'h00};
    @(posedge clk);
    req       <= '{OP_ADD, 8'h02, 8'h03, 8'h00};
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    chk({15'h0000, res_valid_reg}, 16'h0001);
    chk(res_reg.data, 16'h0001);
    n = 0;
    repeat (4) begin
      @(posedge clk);
      #1;
      if (res_valid_reg !== 1'b0) n++;
    end
    chk(16'(n), 16'h0000);
    // Reset in mid-run clears outputs and the product pair, then a plain add works again
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk({6'h00, busy_reg, res_valid_reg, res_reg.dest, flags_reg}, 16'h0000);
    chk({r1_reg, r0_reg}, 16'h0000);
    @(posedge clk);
    arst_n <= 1'b1;
    run_row(rows[0]);
    test_done;
  end
endmodule : tb_top
`default_nettype wire
